// ===== core/display_sync_pkg.sv
// Constants and types shared by the display sync and panel power block
package display_sync_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_TIM_TOTAL = 8'h0c;
  localparam logic [7:0] OFF_TIM_SYNC = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int BIT_PANEL_EN = 0;
  localparam int BIT_VSYNC_EN = 1;
  localparam int BIT_HSYNC_EN = 2;
  localparam int BIT_BLANK_EN = 3;
  localparam int BIT_DDC_CLK = 4;
  localparam int BIT_TG_EN = 5;
  localparam int BIT_VIRQ_EN = 6;
  localparam int BIT_BLINK_EN = 7;
  localparam int BIT_HSYNC_POL = 8;
  localparam int BIT_VSYNC_POL = 9;
  localparam int BIT_BLINK_RATE = 16;
  localparam int POS_SEQ_DELAY = 17;
  localparam logic [31:0] CFG_WMASK = 32'h000f_03ff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Status and mask bits
  localparam int ST_VIRQ = 0;
  localparam int ST_PANEL_DONE = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;

  // Timing defaults: {vertical, horizontal}
  localparam logic [31:0] TIM_TOTAL_RESET = 32'h020d_0320;
  localparam logic [31:0] TIM_SYNC_RESET = 32'h01ea_0290;
  localparam int DEF_HSYNC_WIDTH = 96;
  localparam int DEF_VSYNC_WIDTH = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_OFF, PWR_VDD, PWR_SIG, PWR_BIAS, PWR_LIGHT
  } pwr_state_t;

  typedef struct packed {
    logic backlight;
    logic bias;
    logic signals;
    logic vdd;
  } panel_power_t;

endpackage

// ===== core/display_sync_output_control.sv
// Display sync outputs, blink, vertical irq and panel power sequencing
//
// The AHB-Lite register port and the register offsets were left to the implementer.
module display_sync_output_control
  import display_sync_pkg::*;
#(
  parameter int HSYNC_WIDTH = DEF_HSYNC_WIDTH,
  parameter int VSYNC_WIDTH = DEF_VSYNC_WIDTH
)
(
  input wire logic sys_clk, // dot clock
  input wire logic rst, // synchronous reset, high
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic crtHsync, // CRT horizontal sync
  output logic crt_vertical_sync_pin, // CRT vertical sync / DDC clock
  output logic blankN, // composite blank, low blanks
  output logic panelHsync, // flat panel horizontal sync
  output logic panelVsync, // flat panel vertical sync
  output panel_power_t panelPower, // panel supply steps
  output logic cursorVisible, // hardware cursor shown
  output logic textVisible, // blinking pixels shown
  output logic irq // interrupt, high level
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic pendReg, writeReg, readyReg;
  logic [7:0] addrReg;
  logic [31:0] rdataReg, cfgReg, cfgNext;
  logic [31:0] timTotalReg, timSyncReg;
  logic [1:0] statusReg, statusNext, maskReg;
  logic [31:0] readData;
  pwr_state_t stReg, stNext;
  logic [15:0] hCount, vCount;

  wire busReq = hsel & htrans[1] & hready;
  wire doWrite = pendReg & writeReg;
  wire wrCfg = doWrite & (addrReg == OFF_CFG);
  wire wrStatus = doWrite & (addrReg == OFF_STATUS);
  wire wrMask = doWrite & (addrReg == OFF_MASK);
  wire timing_generator_enable = cfgReg[BIT_TG_EN];
  wire wrTotal = doWrite & (addrReg == OFF_TIM_TOTAL) & ~timing_generator_enable;
  wire wrSync = doWrite & (addrReg == OFF_TIM_SYNC) & ~timing_generator_enable;

  assign cfgNext = wrCfg ? (hwdata & CFG_WMASK) : cfgReg;

  assign readData =
    (addrReg == OFF_CFG) ? cfgReg :
    (addrReg == OFF_STATUS) ? {30'h0, statusReg} :
    (addrReg == OFF_MASK) ? {30'h0, maskReg} :
    (addrReg == OFF_TIM_TOTAL) ? timTotalReg :
    (addrReg == OFF_TIM_SYNC) ? timSyncReg :
    (addrReg == OFF_STATE) ? {vCount, 13'h0, stReg} :
    32'h0;

  // One wait state per transfer so a read right after a write
  // already sees the written value.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pendReg <= 1'b0;
      writeReg <= 1'b0;
      addrReg <= 8'h00;
      readyReg <= 1'b1;
      rdataReg <= 32'h0;
    end
    else
    begin
      pendReg <= busReq;
      readyReg <= ~busReq;
      if (busReq)
      begin
        writeReg <= hwrite;
        addrReg <= haddr[7:0];
      end
      if (pendReg)
        rdataReg <= writeReg ? 32'h0 : readData;
    end
  end

  assign hrdata = rdataReg;
  assign hreadyout = readyReg;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfgReg <= CFG_RESET;
      maskReg <= STATUS_RESET;
      timTotalReg <= TIM_TOTAL_RESET;
      timSyncReg <= TIM_SYNC_RESET;
    end
    else
    begin
      cfgReg <= cfgNext;
      if (wrMask)
        maskReg <= hwdata[1:0];
      if (wrTotal)
        timTotalReg <= hwdata;
      if (wrSync)
        timSyncReg <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // Timing generator
  // ----------------------------------------------------------------
  wire tgHold = rst | ~timing_generator_enable;
  wire [15:0] hTotal = timTotalReg[15:0];
  wire [15:0] vTotal = timTotalReg[31:16];
  wire [15:0] hsStart = timSyncReg[15:0];
  wire [15:0] vsStart = timSyncReg[31:16];
  wire [15:0] hsEnd = hsStart + 16'(HSYNC_WIDTH);
  wire [15:0] vsEnd = vsStart + 16'(VSYNC_WIDTH);
  wire lineEnd = (hCount == hTotal - 16'h0001);
  wire frameEnd = lineEnd & (vCount == vTotal - 16'h0001);
  wire hsyncRaw = (hCount >= hsStart) & (hCount < hsEnd);
  wire vsyncRaw = (vCount >= vsStart) & (vCount < vsEnd);
  wire blankRaw = (hCount >= hsStart) | (vCount >= vsStart);
  wire vsEvent = timing_generator_enable & lineEnd & (vCount == vsStart - 16'h0001);

  // Both dot counters restart while timing is off
  always_ff @(posedge sys_clk)
  begin
    if (tgHold)
    begin
      hCount <= 16'h0000;
      vCount <= 16'h0000;
    end
    else if (lineEnd)
    begin
      hCount <= 16'h0000;
      vCount <= frameEnd ? 16'h0000 : vCount + 16'h0001;
    end
    else
      hCount <= hCount + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Blink
  // ----------------------------------------------------------------
  logic [5:0] blinkCnt;
  wire blinkEn = cfgReg[BIT_BLINK_EN];
  wire blinkSlow = cfgReg[BIT_BLINK_RATE];
  wire cursorPhase = blinkSlow ? blinkCnt[4] : blinkCnt[3];
  wire textPhase = blinkSlow ? blinkCnt[5] : blinkCnt[4];

  always_ff @(posedge sys_clk)
  begin
    if (tgHold)
      blinkCnt <= 6'h00;
    else if (frameEnd)
      blinkCnt <= blinkCnt + 6'h01;
  end

  // ----------------------------------------------------------------
  // Panel power sequencer
  // ----------------------------------------------------------------
  logic [2:0] dlyCnt;
  pwr_state_t stUp, stDown;
  panel_power_t panelNext;
  wire panelEn = cfgReg[BIT_PANEL_EN];
  wire [2:0] seqDelay = cfgReg[POS_SEQ_DELAY +: 3];
  wire goUp = panelEn & (stReg != PWR_LIGHT);
  wire goDown = ~panelEn & (stReg != PWR_OFF);
  wire moving = goUp | goDown;
  // Nonzero delays count frames, so they stall while timing is off
  wire delayDone = (seqDelay == 3'h0) |
    (frameEnd & (dlyCnt == seqDelay - 3'h1));
  wire stepNow = moving & delayDone;

  always_comb
  begin
    stUp = stReg;
    stDown = stReg;
    case (stReg)
      PWR_OFF: stUp = PWR_VDD;
      PWR_VDD:
      begin
        stUp = PWR_SIG;
        stDown = PWR_OFF;
      end
      PWR_SIG:
      begin
        stUp = PWR_BIAS;
        stDown = PWR_VDD;
      end
      PWR_BIAS:
      begin
        stUp = PWR_LIGHT;
        stDown = PWR_SIG;
      end
      PWR_LIGHT: stDown = PWR_BIAS;
      default:
      begin
        stUp = PWR_OFF;
        stDown = PWR_OFF;
      end
    endcase
  end

  assign stNext = !stepNow ? stReg : (goUp ? stUp : stDown);

  always_comb
  begin
    panelNext.vdd = (stNext != PWR_OFF);
    panelNext.signals = (stNext == PWR_SIG) | (stNext == PWR_BIAS) |
      (stNext == PWR_LIGHT);
    panelNext.bias = (stNext == PWR_BIAS) | (stNext == PWR_LIGHT);
    panelNext.backlight = (stNext == PWR_LIGHT);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stReg <= PWR_OFF;
      dlyCnt <= 3'h0;
    end
    else
    begin
      stReg <= stNext;
      dlyCnt <= (!moving | stepNow) ? 3'h0 :
        (frameEnd ? dlyCnt + 3'h1 : dlyCnt);
    end
  end

  // ----------------------------------------------------------------
  // Status, mask, interrupt
  // ----------------------------------------------------------------
  wire vienBit = cfgReg[BIT_VIRQ_EN];
  wire panelDone = stepNow &
    (stNext == (panelEn ? PWR_LIGHT : PWR_OFF));

  // Hardware set wins over a write-one clear in the same cycle
  always_comb
  begin
    statusNext[ST_VIRQ] = vienBit & ((vsEvent) |
      (statusReg[ST_VIRQ] & ~(wrStatus & hwdata[ST_VIRQ])));
    statusNext[ST_PANEL_DONE] = panelDone |
      (statusReg[ST_PANEL_DONE] & ~(wrStatus & hwdata[ST_PANEL_DONE]));
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  wire hsEn = cfgReg[BIT_HSYNC_EN];
  wire vsEn = cfgReg[BIT_VSYNC_EN];
  wire hsOut = hsEn & (timing_generator_enable & hsyncRaw ^ cfgReg[BIT_HSYNC_POL]);
  wire vsOut = vsEn ? (timing_generator_enable & vsyncRaw ^ cfgReg[BIT_VSYNC_POL]) :
    cfgReg[BIT_DDC_CLK];
  wire blankOut = cfgReg[BIT_BLANK_EN] & ~(blankRaw | ~timing_generator_enable);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      statusReg <= STATUS_RESET;
      irq <= 1'b0;
      crtHsync <= 1'b0;
      crt_vertical_sync_pin <= 1'b0;
      blankN <= 1'b0;
      panelHsync <= 1'b0;
      panelVsync <= 1'b0;
      panelPower <= '0;
      cursorVisible <= 1'b1;
      textVisible <= 1'b1;
    end
    else
    begin
      statusReg <= statusNext;
      irq <= |(statusNext & maskReg);
      crtHsync <= hsOut;
      crt_vertical_sync_pin <= vsOut;
      blankN <= blankOut;
      panelHsync <= panelNext.signals & timing_generator_enable & hsyncRaw;
      panelVsync <= panelNext.signals & timing_generator_enable & vsyncRaw;
      panelPower <= panelNext;
      cursorVisible <= ~blinkEn | ~cursorPhase;
      textVisible <= ~blinkEn | ~textPhase;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence vsArm;
    vienBit && vsEvent;
  endsequence
  sequence panelWake;
    panelEn && stReg == PWR_OFF && seqDelay == 3'h0;
  endsequence

  hsync_off_a: assert property (!hsEn |=> !crtHsync)
    else $error("hsync not low while disabled");
  vsync_ddc_a: assert property (!vsEn |=>
    crt_vertical_sync_pin == $past(cfgReg[BIT_DDC_CLK]))
    else $error("vsync pin not following ddc clock");
  hsync_pol_a: assert property (hsEn && timing_generator_enable && !hsyncRaw |=>
    crtHsync == $past(cfgReg[BIT_HSYNC_POL]))
    else $error("hsync idle level wrong");
  vsync_pol_a: assert property (vsEn && timing_generator_enable && vsyncRaw |=>
    crt_vertical_sync_pin == !$past(cfgReg[BIT_VSYNC_POL]))
    else $error("vsync pulse level wrong");
  blank_off_a: assert property (!cfgReg[BIT_BLANK_EN] |=> !blankN)
    else $error("blank not low while disabled");
  virq_set_a: assert property (vsArm |=> statusReg[ST_VIRQ])
    else $error("vertical irq not raised");
  virq_clear_a: assert property (!vienBit |=> !statusReg[ST_VIRQ])
    else $error("vertical irq pending while disabled");
  tg_hold_a: assert property (!timing_generator_enable |=> hCount == 16'h0
    && vCount == 16'h0)
    else $error("dot counters run while timing off");
  panel_order_a: assert property (panelPower.backlight |->
    panelPower.bias && panelPower.signals && panelPower.vdd)
    else $error("panel supply order broken");
  panel_fast_a: assert property (panelWake |=> stReg == PWR_VDD
    ##1 stReg == PWR_SIG)
    else $error("zero delay step not one clock");
  panel_sync_a: assert property (!panelPower.signals |->
    !panelHsync && !panelVsync)
    else $error("panel sync active before signals step");
  blink_off_a: assert property (!blinkEn |=>
    cursorVisible && textVisible)
    else $error("blinking while blink disabled");

endmodule

// ===== verif/display_partner_model.sv
// CRT monitor and flat panel model: counts sync levels, checks supply steps
module display_partner_model
  import display_sync_pkg::*;
(
  input wire logic sys_clk, // dot clock
  input wire logic clr, // restart the counts
  input wire logic crtHsync, // CRT horizontal sync
  input wire logic crt_vertical_sync_pin, // CRT vertical sync or DDC clock
  input wire logic blankN, // composite blank, high shown
  input wire logic panelHsync, // panel horizontal sync
  input wire logic panelVsync, // panel vertical sync
  input wire panel_power_t panelPower, // panel supply steps
  output int hsHigh, // cycles CRT hsync high
  output int vsHigh, // cycles CRT vsync high
  output int blHigh, // cycles display active
  output int phHigh, // cycles panel hsync high
  output int pvHigh, // cycles panel vsync high
  output logic stepBad // illegal supply combination seen
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [3:0] pw = panelPower;

  initial stepBad = 1'b0;

  // Counts only definite highs, so an unknown level never passes as a pulse
  always @(posedge sys_clk)
  begin
    hsHigh <= clr ? 0 : hsHigh + int'(crtHsync === 1'b1);
    vsHigh <= clr ? 0 : vsHigh + int'(crt_vertical_sync_pin === 1'b1);
    blHigh <= clr ? 0 : blHigh + int'(blankN === 1'b1);
    phHigh <= clr ? 0 : phHigh + int'(panelHsync === 1'b1);
    pvHigh <= clr ? 0 : pvHigh + int'(panelVsync === 1'b1);
    // A panel that sees bias or light before its supply is damaged
    if (!(pw inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}))
      stepBad <= 1'b1;
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the display sync and panel power block
module testbench;
  import display_sync_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Short frame: 20 dots by 10 lines
  // ----------------------------------------------------------------
  localparam int HW = 4;
  localparam int VW = 1;
  localparam int H = 20;
  localparam int V = 10;
  localparam int FRAME = H * V;
  localparam logic [31:0] TG = 32'h1 << BIT_TG_EN;
  localparam logic [31:0] HS = 32'h1 << BIT_HSYNC_EN;
  localparam logic [31:0] VS = 32'h1 << BIT_VSYNC_EN;
  localparam logic [31:0] BL = 32'h1 << BIT_BLANK_EN;
  localparam logic [31:0] DDC = 32'h1 << BIT_DDC_CLK;
  localparam logic [31:0] HP = 32'h1 << BIT_HSYNC_POL;
  localparam logic [31:0] VP = 32'h1 << BIT_VSYNC_POL;
  localparam logic [31:0] PE = 32'h1 << BIT_PANEL_EN;
  localparam logic [31:0] VI = 32'h1 << BIT_VIRQ_EN;
  localparam logic [31:0] BK = 32'h1 << BIT_BLINK_EN;
  localparam logic [31:0] BR = 32'h1 << BIT_BLINK_RATE;
  localparam logic [31:0] D2 = 32'h2 << POS_SEQ_DELAY;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic clr = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, crtHsync, crt_vertical_sync_pin, blankN;
  logic panelHsync, panelVsync, cursorVisible, textVisible, irq, stepBad;
  panel_power_t panelPower;
  int hsHigh, vsHigh, blHigh, phHigh, pvHigh, n;
  int n_fail = 0;
  int compares = 0;

  always #50 sys_clk = ~sys_clk;

  display_sync_output_control #(.HSYNC_WIDTH(HW), .VSYNC_WIDTH(VW)) dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .crtHsync(crtHsync), .crt_vertical_sync_pin(crt_vertical_sync_pin),
    .blankN(blankN), .panelHsync(panelHsync), .panelVsync(panelVsync),
    .panelPower(panelPower), .cursorVisible(cursorVisible),
    .textVisible(textVisible), .irq(irq));

  display_partner_model partner (
    .sys_clk(sys_clk), .clr(clr), .crtHsync(crtHsync),
    .crt_vertical_sync_pin(crt_vertical_sync_pin), .blankN(blankN), .panelHsync(panelHsync),
    .panelVsync(panelVsync),
    .panelPower(panelPower), .hsHigh(hsHigh), .vsHigh(vsHigh),
    .blHigh(blHigh), .phHigh(phHigh), .pvHigh(pvHigh), .stepBad(stepBad));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] pick(input int w);
    case (w)
      0: return panelPower;
      1: return {3'h0, cursorVisible};
      2: return {3'h0, textVisible};
      3: return {3'h0, irq};
      default: return {3'h0, hreadyout};
    endcase
  endfunction

  // Edges until the picked output is seen at v; a hang ends the run
  task automatic wait_for(input int w, input logic [3:0] v, output int c);
    c = 0;
    while (pick(w) !== v && c < 20000)
    begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 20000)
    begin
      n_fail++;
      $display("ERROR %0t wait timed out", $time);
      end_sim();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int c;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge sys_clk);
    wait_for(4, 4'h1, c);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    wait_for(4, 4'h1, c);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // One full frame of level counts in the partner
  task automatic window();
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (FRAME) @(posedge sys_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({crtHsync, crt_vertical_sync_pin, blankN, irq, 4'(panelPower)}, 32'h0);
    chk({cursorVisible, textVisible, hresp}, 32'h6);
    rdchk(OFF_CFG, CFG_RESET);
    rdchk(OFF_TIM_TOTAL, TIM_TOTAL_RESET);
    rdchk(OFF_TIM_SYNC, TIM_SYNC_RESET);
    ahb(1'b1, OFF_CFG, 32'hfff0_fc00);
    rdchk(OFF_CFG, 32'h0);
    rdchk(8'h40, 32'h0);
  endtask

  task automatic t_timing();
    ahb(1'b1, OFF_TIM_TOTAL, {16'(V), 16'(H)});
    ahb(1'b1, OFF_TIM_SYNC, 32'h0007_000c);
    ahb(1'b1, OFF_CFG, HS | VS | BL);
    window();
    chk(hsHigh + vsHigh + blHigh, 0);
    ahb(1'b1, OFF_CFG, TG);
    ahb(1'b1, OFF_TIM_TOTAL, 32'h1234_5678);
    rdchk(OFF_TIM_TOTAL, {16'(V), 16'(H)});
  endtask

  // Last two rows are the host clocking the monitor's id data by hand
  task automatic t_sync();
    logic [31:0] cf [5] = '{TG | HS | VS | BL, TG | HS | VS | BL | HP | VP,
                            TG | HP, TG | DDC, TG};
    int eh [5] = '{HW * V, FRAME - HW * V, 0, 0, 0};
    int ev [5] = '{VW * H, FRAME - VW * H, 0, FRAME, 0};
    int eb [5] = '{12 * 7, 12 * 7, 0, 0, 0};
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b1, OFF_CFG, cf[i]);
      window();
      chk(hsHigh, eh[i]);
      chk(vsHigh, ev[i]);
      chk(blHigh, eb[i]);
      chk(phHigh, 0);
      chk(pvHigh, 0);
    end
  endtask

  task automatic t_panel();
    ahb(1'b1, OFF_CFG, TG | PE);
    wait_for(0, 4'hf, n);
    chk(n < 8, 1);
    window();
    chk(hsHigh, 0);
    chk(phHigh, HW * V);
    chk(pvHigh, VW * H);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[ST_PANEL_DONE], 1'b1);
    ahb(1'b1, OFF_CFG, TG);
    wait_for(0, 4'h0, n);
    ahb(1'b1, OFF_CFG, TG | PE | D2);
    wait_for(0, 4'h3, n);
    wait_for(0, 4'h7, n);
    chk(n, 2 * FRAME);
    wait_for(0, 4'hf, n);
    ahb(1'b1, OFF_CFG, TG | D2);
    wait_for(0, 4'h7, n);
    wait_for(0, 4'h3, n);
    chk(n, 2 * FRAME);
    wait_for(0, 4'h0, n);
    chk(stepBad, 1'b0);
  endtask

  task automatic t_irq();
    ahb(1'b1, OFF_MASK, 32'h1);
    ahb(1'b1, OFF_CFG, TG | VI);
    wait_for(3, 4'h1, n);
    chk(n <= FRAME + 8, 1);
    ahb(1'b1, OFF_STATUS, 32'h1);
    rdchk(OFF_STATUS, 32'h1 << ST_PANEL_DONE);
    chk(irq, 1'b0);
    ahb(1'b1, OFF_MASK, 32'h0);
    repeat (FRAME + 10) @(posedge sys_clk);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk({rd[ST_VIRQ], irq}, 2'h2);
    ahb(1'b1, OFF_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1);
    ahb(1'b1, OFF_CFG, TG);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk({rd[ST_VIRQ], irq}, 2'h0);
  endtask

  task automatic t_blink();
    logic [31:0] cf [3] = '{TG | BK, TG | BK, TG | BK | BR};
    int w [3] = '{1, 2, 1};
    int f [3] = '{8, 16, 16};
    for (int i = 0; i < 3; i++)
    begin
      ahb(1'b1, OFF_CFG, cf[i]);
      // Let the new rate reach the pins so no half phase is timed
      @(posedge sys_clk);
      wait_for(w[i], 4'h1, n);
      wait_for(w[i], 4'h0, n);
      wait_for(w[i], 4'h1, n);
      chk(n, f[i] * FRAME);
    end
    ahb(1'b1, OFF_CFG, TG);
    repeat (17 * FRAME) @(posedge sys_clk);
    chk({cursorVisible, textVisible}, 2'h3);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_timing();
    t_sync();
    t_panel();
    t_irq();
    t_blink();
    end_sim();
  end
endmodule
